/* src/pec_counters.sv */
// Overview of operation
// R1: interrupt on transfer only when enable set
// R2: transfer flag set after latch copy
// R3: status read clears transfer flag, interrupt
// R4: overrun when transfer precedes acknowledge
// R5: status read clears overrun flag
// R6: count address write latches all counters
// R7: latch and reset lose no events
// R8: software writes one count address per poll
// R9: holding data ready within 27 periods
// R10: software waits before reading counts
// R11: holding registers undefined until first latch
// R12: 7-bit framing error count at 49
// R13: framing errors ignored when frame lost
// R14: 10-bit far block count at 4A/4B
// R15: far block errors ignored when frame lost
// R16: crc count low byte at 4C
// R17: crc count high bits at 4D
// R18: crc errors ignored when multiframe unaligned
// R19: 13-bit line code count at 4E/4F
// R20: irq level; counters saturate
`timescale 1ns/10ps
`include "pec_regs.svh"

module pec_counters #(
    parameter int FER_W = `PEC_FER_W,
    parameter int FAR_BLOCK_ERROR_COUNT_W = `PEC_FAR_BLOCK_ERROR_COUNT_W,
    parameter int CRC_W = `PEC_CRC_W,
    parameter int LCV_W = `PEC_LCV_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic framing_error_evt,
    input wire logic far_block_error_evt,
    input wire logic crc_error_evt,
    input wire logic line_code_violation_evt,
    input wire logic frame_alignment_lost,
    input wire logic crc_multiframe_unaligned,
    output logic irq
);

    localparam int SETTLE_CYC = (`PEC_SETTLE_NS + `PEC_CLK_NS - 1) / `PEC_CLK_NS;

    initial begin
        if (FER_W < 1 || FER_W > 8 || FAR_BLOCK_ERROR_COUNT_W < 9 || FAR_BLOCK_ERROR_COUNT_W > 16 || CRC_W < 9 || CRC_W > 16
            || LCV_W < 9 || LCV_W > 16 || `PEC_LATCH_CYCLES > `PEC_LATCH_MAX_PERIODS
            || SETTLE_CYC < 1) begin
            $error("pec_counters: unsupported counter widths");
        end
    end

    typedef struct packed {
        pec_pkg::pec_latch_t lstate;
        logic transfer_irq_enable;
        logic transfer_done_flag;
        logic holding_overrun_flag;
        logic [FER_W-1:0] fer_cnt;
        logic [FAR_BLOCK_ERROR_COUNT_W-1:0] far_block_error_count_cnt;
        logic [CRC_W-1:0] crc_cnt;
        logic [LCV_W-1:0] lcv_cnt;
        logic [FER_W-1:0] fer_hold;
        logic [FAR_BLOCK_ERROR_COUNT_W-1:0] far_block_error_count_hold;
        logic [CRC_W-1:0] crc_hold;
        logic [LCV_W-1:0] lcv_hold;
        logic [31:0] rdata;
    } pec_state_t;

    pec_state_t st;
    pec_state_t next_st;

    logic access;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic [9:0] idx;
    logic is_count;
    logic latch_req;
    logic copy_now;
    logic fer_inc;
    logic far_block_error_count_inc;
    logic crc_inc;
    logic lcv_inc;
    logic [31:0] rd_mux;

    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (idx >= 10'(`PEC_IDX_CTRL)) && (idx <= 10'(`PEC_IDX_LCV_HI));
    assign is_count = addr_ok && (idx != 10'(`PEC_IDX_CTRL));
    // R6: count write
    assign latch_req = wr_acc && is_count;
    assign copy_now = (st.lstate == pec_pkg::PEC_COPY);
    // R13: suppress on frame loss
    assign fer_inc = framing_error_evt && !frame_alignment_lost;
    // R15: suppress on frame loss
    assign far_block_error_count_inc = far_block_error_evt && !frame_alignment_lost;
    // R18: suppress when unaligned
    assign crc_inc = crc_error_evt && !crc_multiframe_unaligned;
    assign lcv_inc = line_code_violation_evt;

    always_comb begin
        rd_mux = 32'h0;
        case (idx)
            10'(`PEC_IDX_CTRL): begin
                rd_mux[`PEC_BIT_TRANSFER_IRQ_ENABLE] = st.transfer_irq_enable;
                rd_mux[`PEC_BIT_TRANSFER_DONE_FLAG] = st.transfer_done_flag;
                rd_mux[`PEC_BIT_OVR] = st.holding_overrun_flag;
            end
            // R12: framing count
            10'(`PEC_IDX_FER): rd_mux[FER_W-1:0] = st.fer_hold;
            // R14: far block split
            10'(`PEC_IDX_FAR_BLOCK_ERROR_COUNT_LO): rd_mux[7:0] = st.far_block_error_count_hold[7:0];
            10'(`PEC_IDX_FAR_BLOCK_ERROR_COUNT_HI): rd_mux[FAR_BLOCK_ERROR_COUNT_W-9:0] = st.far_block_error_count_hold[FAR_BLOCK_ERROR_COUNT_W-1:8];
            // R16: crc low byte
            10'(`PEC_IDX_CRC_LO): rd_mux[7:0] = st.crc_hold[7:0];
            // R17: crc high bits
            10'(`PEC_IDX_CRC_HI): rd_mux[CRC_W-9:0] = st.crc_hold[CRC_W-1:8];
            // R19: line code split
            10'(`PEC_IDX_LCV_LO): rd_mux[7:0] = st.lcv_hold[7:0];
            10'(`PEC_IDX_LCV_HI): rd_mux[LCV_W-9:0] = st.lcv_hold[LCV_W-1:8];
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        next_st = st;
        // R9: copy two cycles later
        case (st.lstate)
            // R7: latch request waits a cycle so copy and clear coincide
            pec_pkg::PEC_IDLE: begin
                if (latch_req) begin
                    next_st.lstate = pec_pkg::PEC_ARM;
                end
            end
            pec_pkg::PEC_ARM: next_st.lstate = pec_pkg::PEC_COPY;
            pec_pkg::PEC_COPY: next_st.lstate = latch_req ? pec_pkg::PEC_ARM : pec_pkg::PEC_IDLE;
            default: next_st.lstate = pec_pkg::PEC_IDLE;
        endcase

        // R20: saturating counters
        if (!(&st.fer_cnt)) next_st.fer_cnt = st.fer_cnt + FER_W'(fer_inc);
        if (!(&st.far_block_error_count_cnt)) next_st.far_block_error_count_cnt = st.far_block_error_count_cnt + FAR_BLOCK_ERROR_COUNT_W'(far_block_error_count_inc);
        if (!(&st.crc_cnt)) next_st.crc_cnt = st.crc_cnt + CRC_W'(crc_inc);
        if (!(&st.lcv_cnt)) next_st.lcv_cnt = st.lcv_cnt + LCV_W'(lcv_inc);

        if (copy_now) begin
            // R6: group copy
            next_st.fer_hold = st.fer_cnt;
            next_st.far_block_error_count_hold = st.far_block_error_count_cnt;
            next_st.crc_hold = st.crc_cnt;
            next_st.lcv_hold = st.lcv_cnt;
            // R7: event on copy edge starts next interval
            next_st.fer_cnt = FER_W'(fer_inc);
            next_st.far_block_error_count_cnt = FAR_BLOCK_ERROR_COUNT_W'(far_block_error_count_inc);
            next_st.crc_cnt = CRC_W'(crc_inc);
            next_st.lcv_cnt = LCV_W'(lcv_inc);
        end

        if (wr_acc && addr_ok && idx == 10'(`PEC_IDX_CTRL)) begin
            next_st.transfer_irq_enable = pwdata[`PEC_BIT_TRANSFER_IRQ_ENABLE];
        end

        // R3: read acknowledges
        // R5: read clears overrun
        if (rd_acc && addr_ok && idx == 10'(`PEC_IDX_CTRL)) begin
            next_st.transfer_done_flag = 1'b0;
            next_st.holding_overrun_flag = 1'b0;
        end
        // R2: set wins over read clear
        // R4: overrun if still unacknowledged
        if (copy_now) begin
            next_st.transfer_done_flag = 1'b1;
            if (st.transfer_done_flag) begin
                next_st.holding_overrun_flag = 1'b1;
            end
        end

        if (rd_acc) begin
            next_st.rdata = addr_ok ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // R11: holding contents meaningless until first latch; zeroed for determinism
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;
    // R1: enable gating
    // R20: level while flag and enable
    assign irq = st.transfer_done_flag && st.transfer_irq_enable;

    // rdata register updates at the access edge; during the access the master samples rd_mux via a comb path, the registered copy otherwise
    assign prdata = rd_acc ? (addr_ok ? rd_mux : 32'h0) : st.rdata;

endmodule

/* src/pec_pkg.sv */
package pec_pkg;
    typedef enum logic [1:0] {
        PEC_IDLE,
        PEC_ARM,
        PEC_COPY
    } pec_latch_t;
endpackage

/* src/pec_regs.svh */
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define PEC_IDX_CTRL 8'h48
`define PEC_IDX_FER 8'h49
`define PEC_IDX_FAR_BLOCK_ERROR_COUNT_LO 8'h4A
`define PEC_IDX_FAR_BLOCK_ERROR_COUNT_HI 8'h4B
`define PEC_IDX_CRC_LO 8'h4C
`define PEC_IDX_CRC_HI 8'h4D
`define PEC_IDX_LCV_LO 8'h4E
`define PEC_IDX_LCV_HI 8'h4F

`define PEC_BIT_OVR 0
`define PEC_BIT_TRANSFER_DONE_FLAG 1
`define PEC_BIT_TRANSFER_IRQ_ENABLE 2

`define PEC_FER_W 7
`define PEC_FAR_BLOCK_ERROR_COUNT_W 10
`define PEC_CRC_W 10
`define PEC_LCV_W 13

// latch-to-update bound, in reference clock periods, and settle time in ns
`define PEC_LATCH_MAX_PERIODS 27
`define PEC_SETTLE_NS 1700
`define PEC_CLK_NS 8
// latch sequence: sync stages then copy; well inside the bound
`define PEC_LATCH_CYCLES 3

`endif

/* verif/pec_counters_sva.sv */
`timescale 1ns/10ps
module pec_counters_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire acc = psel && penable;
    wire rd = acc && !pwrite;
    wire stat_rd = rd && paddr == 12'h120;
    wire ctrl_wr = acc && pwrite && paddr == 12'h120;
    wire cnt_wr = acc && pwrite && paddr >= 12'h124 && paddr <= 12'h13C && paddr[1:0] == 2'h0;
    wire bad_adr = paddr[11:2] < 10'h048 || paddr[11:2] > 10'h04F || paddr[1:0] != 2'h0;
    sequence stat_rd_s;
        stat_rd;
    endsequence
    sequence two_reads_s;
        stat_rd_s ##3 stat_rd_s;
    endsequence
    ready_now_a: assert property (acc |-> pready) else $error("access without ready");
    unmapped_refused_a: assert property (acc && bad_adr |-> pslverr)
        else $error("unmapped access not refused");
    unmapped_zero_a: assert property (rd && bad_adr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    irq_cause_a: assert property ($rose(irq) |-> $past(cnt_wr, 3) || $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("irq without transfer");
    irq_hold_a: assert property (irq && !stat_rd && !ctrl_wr |=> irq) else $error("irq dropped early");
    irq_drop_a: assert property (stat_rd_s |-> ##1 !irq) else $error("irq kept after status read");
    flags_clear_a: assert property (two_reads_s |-> prdata[1:0] == 2'h0) else $error("flags kept");
    fer_width_a: assert property (rd && paddr == 12'h124 |-> prdata[31:7] == 25'h0)
        else $error("framing count too wide");
    far_block_error_count_width_a: assert property (rd && paddr == 12'h12C |-> prdata[31:2] == 30'h0)
        else $error("far block high too wide");
endmodule
bind pec_counters pec_counters_sva sva (.*);

/* verif/performance_error_counters_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
module performance_error_counters_test;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, lost, unal;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rs;
    logic [3:0] ev;
    logic [32:0] q[$];
    int bad_count, comparisons, fe, fb, ce, lc;
    pec_counters uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .framing_error_evt(ev[0]),
        .far_block_error_evt(ev[1]), .crc_error_evt(ev[2]), .line_code_violation_evt(ev[3]),
        .frame_alignment_lost(lost), .crc_multiframe_unaligned(unal), .irq(irq));
    function logic [31:0] xs(input logic [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function int inc(input int v, input int m);
        return v < m ? v + 1 : v;
    endfunction
    task report_and_stop;
        $display("checks %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task run(input int n);
        repeat (n) begin
            rs = xs(rs);
            ev <= rs[3:0];
            lost <= &rs[5:4];
            unal <= &rs[7:6];
            // suppression and saturation
            if (rs[0] && !(&rs[5:4])) fe = inc(fe, 127);
            if (rs[1] && !(&rs[5:4])) fb = inc(fb, 1023);
            if (rs[2] && !(&rs[7:6])) ce = inc(ce, 1023);
            if (rs[3]) lc = inc(lc, 8191);
            @(posedge clk);
        end
        ev <= 4'h0;
        @(posedge clk);
        apb(1'b1, 12'h124 + {7'h0, rs[10:8] % 3'h7, 2'h0}, 32'h0);
        repeat (27) @(posedge clk);
        rd(12'h124, fe);
        rd(12'h128, fb[7:0]);
        rd(12'h12C, fb[9:8]);
        rd(12'h130, ce[7:0]);
        rd(12'h134, ce[9:8]);
        rd(12'h138, lc[7:0]);
        rd(12'h13C, lc[12:8]);
        {fe, fb, ce, lc} = '0;
    endtask
    always @(negedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            `CHK({pslverr, prdata}, q.pop_front())
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 20000);
        bad_count++;
        report_and_stop;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, lost, unal} = '0;
        rst = 1'b1;
        rs = 32'h25;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b1, 12'h120, 32'hFFFFFFFF);
        rd(12'h120, 32'h4);
        run(600);
        `CHK(irq, 1'b1)
        rd(12'h120, 32'h6);
        rd(12'h120, 32'h4);
        `CHK(irq, 1'b0)
        $display("end counts");
        apb(1'b1, 12'h120, 32'h0);
        run(5);
        run(5);
        `CHK(irq, 1'b0)
        rd(12'h120, 32'h3);
        rd(12'h120, 32'h0);
        $display("end overrun");
        apb(1'b1, 12'h122, 32'h4);
        rd(12'h140, {1'b1, 32'h0});
        rd(12'h122, {1'b1, 32'h0});
        rd(12'h120, 32'h0);
        $display("end unmapped");
        report_and_stop;
    end
endmodule
